// ==== include/fbcp_map.svh ====
// Purpose: offsets, field positions and sizes for flash block guard logic
// Assumes: byte-wide configuration space, 22-bit program addresses
// Notes:   definitions only
`ifndef FBCP_MAP_SVH
`define FBCP_MAP_SVH
`define FBCP_CFG_EXT_BLK   22'h300008
`define FBCP_CFG_EXT_BOOT  22'h300009
`define FBCP_CFG_WR_BLK    22'h30000a
`define FBCP_CFG_WR_BOOT   22'h30000b
`define FBCP_CFG_RD_BLK    22'h30000c
`define FBCP_CFG_RD_BOOT   22'h30000d
`define FBCP_DEVID_LO      22'h3ffffe
`define FBCP_DEVID_HI      22'h3fffff
`define FBCP_BIT_EEPROM    3'h7
`define FBCP_BIT_BOOT      3'h6
`define FBCP_BIT_CFG       3'h5
`define FBCP_ALL_ONES      8'hff
`define FBCP_ZERO          8'h00
`define FBCP_BOOT_SMALL    22'h000200
`define FBCP_BOOT_LARGE    22'h000800
`define FBCP_END_8K        22'h002000
`define FBCP_END_16K       22'h004000
`define FBCP_END_32K       22'h008000
`define FBCP_END_64K       22'h010000
`define FBCP_SZ_8K         2'h0
`define FBCP_SZ_16K        2'h1
`define FBCP_SZ_32K        2'h2
`define FBCP_SZ_64K        2'h3
// identification word: value is arbitrary and names no real part
`define FBCP_DEVID_WORD    16'h5a5a
`endif

// ==== include/fbcp_pkg.sv ====
// Purpose: types for flash block guard logic
// Assumes: fbcp_map.svh holds the numbers
// Notes:   none
package fbcp_pkg;
   typedef enum logic [2:0] {
      FBCP_BLK_BOOT, FBCP_BLK_0, FBCP_BLK_1, FBCP_BLK_2, FBCP_BLK_3,
      FBCP_BLK_NONE, FBCP_BLK_CFG
   } fbcp_region_t;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [21:0] addr;
      logic [21:0] fetch_addr;
      logic [7:0]  wdata;
   } fbcp_req_t;
   typedef struct packed {
      logic       valid;
      logic       allowed;
      logic [7:0] rdata;
   } fbcp_rsp_t;
endpackage

// ==== logic/fbcp_guard.sv ====
// Purpose: flash and eeprom access guard with one-way guard bits
// Assumes: single clock; programmer strobes synchronous to clock_in
// Notes:   guard bits are held in flops standing in for config cells
`timescale 1ns/1ps
`include "fbcp_map.svh"
`default_nettype none
module fbcp_guard (
   input  wire logic              clock_in,      // core clock
   input  wire logic              arst_n_in,     // async reset, low
   input  wire logic [1:0]        mem_size_in,   // memory size strap
   input  wire fbcp_pkg::fbcp_req_t cpu_req_in,  // cpu table access
   output fbcp_pkg::fbcp_rsp_t    cpu_rsp_out,   // cpu table answer
   input  wire fbcp_pkg::fbcp_req_t prg_req_in,  // programmer access
   output fbcp_pkg::fbcp_rsp_t    prg_rsp_out,   // programmer answer
   input  wire logic              cpu_ee_valid_in, // cpu eeprom request
   input  wire logic              cpu_ee_write_in, // cpu eeprom write
   output logic                   cpu_ee_ok_out,   // cpu eeprom allowed
   input  wire logic              prg_ee_valid_in, // prog eeprom request
   input  wire logic              prg_ee_write_in, // prog eeprom write
   output logic                   prg_ee_ok_out,   // prog eeprom allowed
   input  wire logic              prg_chip_erase_in, // programmer erase all
   input  wire logic              prg_blk_erase_in,  // programmer erase blk
   input  wire logic [2:0]        prg_erase_blk_in,  // region to erase
   output logic [21:0]            flash_addr_out,  // flash array address
   input  wire logic [7:0]        flash_rdata_in,  // flash array data
   output logic                   flash_we_out,    // flash write strobe
   output logic [7:0]             flash_wdata_out  // flash write data
);
   // one bit per region: [4]=boot, [3:0]=blocks 3..0
   logic [4:0] ext_lock_r;
   logic [4:0] wr_lock_r;
   logic [4:0] rd_lock_r;
   logic       ee_ext_lock_r;
   logic       ee_wr_lock_r;
   logic       cfg_wr_lock_r;
   logic [1:0] size_r;
   logic       size_cap_r;
   fbcp_pkg::fbcp_rsp_t cpu_rsp_r;
   fbcp_pkg::fbcp_rsp_t prg_rsp_r;
   // a literal cannot be part-selected, so the id word gets a name
   localparam logic [15:0] DEVID_WORD = `FBCP_DEVID_WORD;

   // decode a program address to its region for the current size
   function automatic fbcp_pkg::fbcp_region_t region_of(
      input logic [21:0] a, input logic [1:0] sz);
      logic [21:0] boot_end;
      logic [21:0] mem_end;
      logic [21:0] q;
      boot_end = (sz == `FBCP_SZ_8K) ? `FBCP_BOOT_SMALL
                                     : `FBCP_BOOT_LARGE;
      unique case (sz)
         `FBCP_SZ_8K:  mem_end = `FBCP_END_8K;
         `FBCP_SZ_16K: mem_end = `FBCP_END_16K;
         `FBCP_SZ_32K: mem_end = `FBCP_END_32K;
         default:      mem_end = `FBCP_END_64K;
      endcase
      q = mem_end >> 2;
      if (a >= `FBCP_CFG_EXT_BLK && a <= `FBCP_CFG_RD_BOOT)
         region_of = fbcp_pkg::FBCP_BLK_CFG;
      else if (a >= mem_end)
         region_of = fbcp_pkg::FBCP_BLK_NONE;
      else if (a < boot_end)
         region_of = fbcp_pkg::FBCP_BLK_BOOT;
      else if (sz == `FBCP_SZ_8K || sz == `FBCP_SZ_16K)
         region_of = (a < (mem_end >> 1)) ? fbcp_pkg::FBCP_BLK_0
                                          : fbcp_pkg::FBCP_BLK_1;
      else if (a < q)
         region_of = fbcp_pkg::FBCP_BLK_0;
      else if (a < (q << 1))
         region_of = fbcp_pkg::FBCP_BLK_1;
      else if (a < (q * 3))
         region_of = fbcp_pkg::FBCP_BLK_2;
      else
         region_of = fbcp_pkg::FBCP_BLK_3;
   endfunction

   // index into a 5-bit lock vector, with small-part blocks 2/3 inert
   function automatic logic lock_of(input logic [4:0] v,
      input fbcp_pkg::fbcp_region_t r, input logic [1:0] sz);
      lock_of = 1'b1;
      unique case (r)
         fbcp_pkg::FBCP_BLK_BOOT: lock_of = v[4];
         fbcp_pkg::FBCP_BLK_0:    lock_of = v[0];
         fbcp_pkg::FBCP_BLK_1:    lock_of = v[1];
         fbcp_pkg::FBCP_BLK_2,
         fbcp_pkg::FBCP_BLK_3:
            lock_of = (sz[1]) ? v[r == fbcp_pkg::FBCP_BLK_3 ? 3 : 2]
                              : 1'b1;
         default:                 lock_of = 1'b1;
      endcase
   endfunction

   function automatic logic [7:0] cfg_read(input logic [21:0] a,
      input logic [4:0] e, input logic [4:0] w, input logic [4:0] r,
      input logic ed, input logic wd, input logic wc);
      cfg_read = `FBCP_ZERO;
      unique case (a)
         `FBCP_CFG_EXT_BLK:  cfg_read = {4'h0, e[3:0]};
         `FBCP_CFG_EXT_BOOT: cfg_read = {ed, e[4], 6'h00};
         `FBCP_CFG_WR_BLK:   cfg_read = {4'h0, w[3:0]};
         `FBCP_CFG_WR_BOOT:  cfg_read = {wd, w[4], wc, 5'h00};
         `FBCP_CFG_RD_BLK:   cfg_read = {4'h0, r[3:0]};
         `FBCP_CFG_RD_BOOT:  cfg_read = {1'b0, r[4], 6'h00};
         default:            cfg_read = `FBCP_ZERO;
      endcase
   endfunction

   fbcp_pkg::fbcp_region_t cpu_reg;
   fbcp_pkg::fbcp_region_t cpu_fetch_reg;
   fbcp_pkg::fbcp_region_t prg_reg;
   logic cpu_ok;
   logic prg_ok;
   logic cpu_is_id;
   logic cpu_cfg_wr;
   logic prg_cfg_wr;
   logic [7:0] cfg_wd;
   logic [21:0] cfg_wa;
   logic [4:0] erase_mask;

   // strap caught once after reset release
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         size_r     <= `FBCP_SZ_64K;
         size_cap_r <= 1'b0;
      end else if (!size_cap_r) begin
         size_r     <= mem_size_in;
         size_cap_r <= 1'b1;
      end
   end

   always_comb begin
      cpu_reg       = region_of(cpu_req_in.addr, size_r);
      cpu_fetch_reg = region_of(cpu_req_in.fetch_addr, size_r);
      prg_reg       = region_of(prg_req_in.addr, size_r);
      cpu_is_id     = cpu_req_in.addr == `FBCP_DEVID_LO ||
                      cpu_req_in.addr == `FBCP_DEVID_HI;
      cpu_ok = 1'b1;
      if (cpu_req_in.write) begin
         if (cpu_reg == fbcp_pkg::FBCP_BLK_NONE || cpu_is_id)
            cpu_ok = 1'b0;
         else if (cpu_reg == fbcp_pkg::FBCP_BLK_CFG)
            cpu_ok = cfg_wr_lock_r;
         else
            cpu_ok = lock_of(wr_lock_r, cpu_reg, size_r);
      end else if (cpu_reg != fbcp_pkg::FBCP_BLK_CFG &&
                   cpu_reg != fbcp_pkg::FBCP_BLK_NONE) begin
         cpu_ok = lock_of(rd_lock_r, cpu_reg, size_r) ||
                  (cpu_fetch_reg == cpu_reg);
      end
      prg_ok = 1'b1;
      if (prg_reg == fbcp_pkg::FBCP_BLK_NONE)
         prg_ok = !prg_req_in.write;
      else if (prg_reg != fbcp_pkg::FBCP_BLK_CFG)
         prg_ok = lock_of(ext_lock_r, prg_reg, size_r) &&
                  (!prg_req_in.write ||
                   lock_of(wr_lock_r, prg_reg, size_r));
      cpu_cfg_wr = cpu_req_in.valid && cpu_req_in.write &&
                   cpu_reg == fbcp_pkg::FBCP_BLK_CFG && cfg_wr_lock_r;
      prg_cfg_wr = prg_req_in.valid && prg_req_in.write &&
                   prg_reg == fbcp_pkg::FBCP_BLK_CFG;
      cfg_wd = prg_cfg_wr ? prg_req_in.wdata : cpu_req_in.wdata;
      cfg_wa = prg_cfg_wr ? prg_req_in.addr : cpu_req_in.addr;
      erase_mask = 5'h00;
      if (prg_blk_erase_in) begin
         unique case (prg_erase_blk_in)
            3'h0:    erase_mask = 5'h10;
            3'h1:    erase_mask = 5'h01;
            3'h2:    erase_mask = 5'h02;
            3'h3:    erase_mask = 5'h04;
            3'h4:    erase_mask = 5'h08;
            default: erase_mask = 5'h00;
         endcase
      end
   end

   // guard bits: writes can only clear, erase (programmer only) sets
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ext_lock_r    <= 5'h1f;
         wr_lock_r     <= 5'h1f;
         rd_lock_r     <= 5'h1f;
         ee_ext_lock_r <= 1'b1;
         ee_wr_lock_r  <= 1'b1;
         cfg_wr_lock_r <= 1'b1;
      end else if (prg_chip_erase_in) begin
         ext_lock_r    <= 5'h1f;
         wr_lock_r     <= 5'h1f;
         rd_lock_r     <= 5'h1f;
         ee_ext_lock_r <= 1'b1;
         ee_wr_lock_r  <= 1'b1;
         cfg_wr_lock_r <= 1'b1;
      end else if (prg_blk_erase_in) begin
         ext_lock_r <= ext_lock_r | erase_mask;
         wr_lock_r  <= wr_lock_r | erase_mask;
         rd_lock_r  <= rd_lock_r | erase_mask;
      end else if (cpu_cfg_wr || prg_cfg_wr) begin
         unique case (cfg_wa)
            `FBCP_CFG_EXT_BLK:
               ext_lock_r[3:0] <= ext_lock_r[3:0] & cfg_wd[3:0];
            `FBCP_CFG_EXT_BOOT: begin
               ext_lock_r[4] <= ext_lock_r[4] & cfg_wd[`FBCP_BIT_BOOT];
               ee_ext_lock_r <= ee_ext_lock_r & cfg_wd[`FBCP_BIT_EEPROM];
            end
            `FBCP_CFG_WR_BLK:
               wr_lock_r[3:0] <= wr_lock_r[3:0] & cfg_wd[3:0];
            `FBCP_CFG_WR_BOOT: begin
               wr_lock_r[4] <= wr_lock_r[4] & cfg_wd[`FBCP_BIT_BOOT];
               ee_wr_lock_r <= ee_wr_lock_r & cfg_wd[`FBCP_BIT_EEPROM];
               if (prg_cfg_wr)
                  cfg_wr_lock_r <= cfg_wr_lock_r &
                                   cfg_wd[`FBCP_BIT_CFG];
            end
            `FBCP_CFG_RD_BLK:
               rd_lock_r[3:0] <= rd_lock_r[3:0] & cfg_wd[3:0];
            default:
               rd_lock_r[4] <= rd_lock_r[4] & cfg_wd[`FBCP_BIT_BOOT];
         endcase
      end
   end

   // flash port serves cpu unless the programmer is active
   always_comb begin
      flash_addr_out  = prg_req_in.valid ? prg_req_in.addr
                                         : cpu_req_in.addr;
      flash_wdata_out = prg_req_in.valid ? prg_req_in.wdata
                                         : cpu_req_in.wdata;
      flash_we_out = prg_req_in.valid
         ? (prg_req_in.write && prg_ok &&
            prg_reg != fbcp_pkg::FBCP_BLK_CFG)
         : (cpu_req_in.valid && cpu_req_in.write && cpu_ok &&
            cpu_reg != fbcp_pkg::FBCP_BLK_CFG);
      cpu_ee_ok_out = cpu_ee_valid_in &&
                      (!cpu_ee_write_in || ee_wr_lock_r);
      prg_ee_ok_out = prg_ee_valid_in && ee_ext_lock_r &&
                      (!prg_ee_write_in || ee_wr_lock_r);
   end

   // answers registered one cycle after the request
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cpu_rsp_r <= '0;
         prg_rsp_r <= '0;
      end else begin
         cpu_rsp_r.valid   <= cpu_req_in.valid && !prg_req_in.valid;
         cpu_rsp_r.allowed <= cpu_ok;
         if (cpu_is_id)
            cpu_rsp_r.rdata <= cpu_req_in.addr[0] ?
               DEVID_WORD[15:8] : DEVID_WORD[7:0];
         else if (cpu_reg == fbcp_pkg::FBCP_BLK_CFG)
            cpu_rsp_r.rdata <= cfg_read(cpu_req_in.addr, ext_lock_r,
               wr_lock_r, rd_lock_r, ee_ext_lock_r, ee_wr_lock_r,
               cfg_wr_lock_r);
         else if (cpu_req_in.write || !cpu_ok ||
                  cpu_reg == fbcp_pkg::FBCP_BLK_NONE)
            cpu_rsp_r.rdata <= `FBCP_ZERO;
         else
            cpu_rsp_r.rdata <= flash_rdata_in;
         prg_rsp_r.valid   <= prg_req_in.valid;
         prg_rsp_r.allowed <= prg_ok;
         if (prg_reg == fbcp_pkg::FBCP_BLK_CFG)
            prg_rsp_r.rdata <= cfg_read(prg_req_in.addr, ext_lock_r,
               wr_lock_r, rd_lock_r, ee_ext_lock_r, ee_wr_lock_r,
               cfg_wr_lock_r);
         else if (prg_req_in.write || !prg_ok ||
                  prg_reg == fbcp_pkg::FBCP_BLK_NONE)
            prg_rsp_r.rdata <= `FBCP_ZERO;
         else
            prg_rsp_r.rdata <= flash_rdata_in;
      end
   end

   assign cpu_rsp_out = cpu_rsp_r;
   assign prg_rsp_out = prg_rsp_r;

   property only_clear_p(logic b);
      @(posedge clock_in) disable iff (!arst_n_in)
      (!b && !prg_chip_erase_in && !prg_blk_erase_in) |=> !b;
   endproperty
   ext_one_way_a: assert property (only_clear_p(ext_lock_r[0]))
      else $error("external lock bit rose without erase");
   cfg_lock_ro_a: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      (cpu_cfg_wr && !prg_cfg_wr && !prg_chip_erase_in &&
       !prg_blk_erase_in) |=> cfg_wr_lock_r == $past(cfg_wr_lock_r))
      else $error("cpu changed config write lock");
   wr_block_a: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      (!prg_req_in.valid && cpu_req_in.valid && cpu_req_in.write &&
       cpu_reg == fbcp_pkg::FBCP_BLK_BOOT && !wr_lock_r[4])
       |-> !flash_we_out)
      else $error("write to locked block reached flash");
   sequence outside_read_s;
      cpu_req_in.valid && !prg_req_in.valid && !cpu_req_in.write &&
      cpu_reg == fbcp_pkg::FBCP_BLK_0 && !rd_lock_r[0] &&
      cpu_fetch_reg != fbcp_pkg::FBCP_BLK_0;
   endsequence
   zero_read_a: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      outside_read_s |=> cpu_rsp_out.rdata == `FBCP_ZERO)
      else $error("protected read returned data");
   ee_read_ok_a: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      (cpu_ee_valid_in && !cpu_ee_write_in) |-> cpu_ee_ok_out)
      else $error("cpu eeprom read refused");
   ee_wr_lock_a: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      !ee_wr_lock_r |-> !(cpu_ee_ok_out && cpu_ee_write_in) &&
                        !(prg_ee_ok_out && prg_ee_write_in))
      else $error("eeprom write passed lock");
   erase_set_a: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      prg_chip_erase_in |=> (&{ext_lock_r, wr_lock_r, rd_lock_r}))
      else $error("chip erase left a guard bit clear");
   prg_ext_a: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      (prg_req_in.valid && prg_reg == fbcp_pkg::FBCP_BLK_1 &&
       !ext_lock_r[1]) |=> !prg_rsp_out.allowed)
      else $error("programmer reached locked block");
endmodule
`default_nettype wire

// ==== testbench/fbcp_flash_model.sv ====
// Purpose: behavioural program flash array beside the guard
// Assumes: 64K bytes, combinational read, write on the clock edge
// Notes:   cells outside the array float, shown as a fixed non-zero byte
`timescale 1ns/1ps
`default_nettype none
module fbcp_flash_model (
   input  wire logic        clock_in,  // core clock
   input  wire logic [21:0] addr_in,   // array address
   input  wire logic        we_in,     // write strobe
   input  wire logic [7:0]  wdata_in,  // write data
   output logic [7:0]       rdata_out  // read data, same cycle
);
   logic [7:0] mem [65536];

   // pattern, zero only where address bytes XOR to 8'h3c, so a zeroed read is told apart from real data
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3c;
      end
   end

   always @(posedge clock_in) begin
      if (we_in) begin
         mem[addr_in[15:0]] <= wdata_in;
      end
   end

   // beyond the array nothing drives the bus; the guard must zero it
   assign rdata_out = (addr_in[21:16] != 6'h00) ? 8'ha5 : mem[addr_in[15:0]];
endmodule
`default_nettype wire

// ==== testbench/fbcp_guard_tb.sv ====
// Purpose: self-checking bench for the flash block guard
// Assumes: inputs change at the falling edge, answers one cycle later
// Notes:   flash contents come from the array model pattern
`timescale 1ns/1ps
`include "fbcp_map.svh"
`default_nettype none
`define CHECK_EQ(got, exp, what) \
   begin total_checks++; if ((got) !== (exp)) begin errors++; \
   $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp); end end
module fbcp_guard_tb;
   logic                clock_in;
   logic                arst_n_in;
   logic [1:0]          mem_size;
   fbcp_pkg::fbcp_req_t cpu_req;
   fbcp_pkg::fbcp_req_t prg_req;
   fbcp_pkg::fbcp_rsp_t cpu_rsp;
   fbcp_pkg::fbcp_rsp_t prg_rsp;
   logic                cpu_ee_valid;
   logic                cpu_ee_write;
   logic                cpu_ee_ok;
   logic                prg_ee_valid;
   logic                prg_ee_write;
   logic                prg_ee_ok;
   logic                chip_erase;
   logic                blk_erase;
   logic [2:0]          erase_blk;
   logic [21:0]         flash_addr;
   logic [7:0]          flash_rdata;
   logic [7:0]          flash_wdata;
   logic                flash_we;
   logic                ok;
   logic [7:0]          rd;
   logic [15:0]         id_word;
   int                  errors;
   int                  total_checks;
   localparam logic [7:0] CFG_DEF [6] = '{8'h0f, 8'hc0, 8'h0f, 8'he0,
                                          8'h0f, 8'h40};

   fbcp_guard uut (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .mem_size_in(mem_size), .cpu_req_in(cpu_req), .cpu_rsp_out(cpu_rsp),
      .prg_req_in(prg_req), .prg_rsp_out(prg_rsp),
      .cpu_ee_valid_in(cpu_ee_valid), .cpu_ee_write_in(cpu_ee_write),
      .cpu_ee_ok_out(cpu_ee_ok), .prg_ee_valid_in(prg_ee_valid),
      .prg_ee_write_in(prg_ee_write), .prg_ee_ok_out(prg_ee_ok),
      .prg_chip_erase_in(chip_erase), .prg_blk_erase_in(blk_erase),
      .prg_erase_blk_in(erase_blk), .flash_addr_out(flash_addr),
      .flash_rdata_in(flash_rdata), .flash_we_out(flash_we),
      .flash_wdata_out(flash_wdata));

   fbcp_flash_model flash (.clock_in(clock_in), .addr_in(flash_addr),
      .we_in(flash_we), .wdata_in(flash_wdata), .rdata_out(flash_rdata));

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   function automatic logic [7:0] pat(input logic [21:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction

   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic end_test(input string name);
      $display("test %s done, errors so far %0d", name, errors);
   endtask

   task automatic do_reset(input logic [1:0] size);
      @(negedge clock_in);
      arst_n_in = 1'b0;
      mem_size = size;
      repeat (20) @(negedge clock_in);
      arst_n_in = 1'b1;
      repeat (2) @(negedge clock_in);
   endtask

   // one request, answer taken in the cycle after the capturing edge
   task automatic access(input logic prg, input logic wr,
                         input logic [21:0] a, input logic [21:0] f,
                         input logic [7:0] wd);
      fbcp_pkg::fbcp_req_t q;
      fbcp_pkg::fbcp_rsp_t s;
      q = '{valid: 1'b1, write: wr, addr: a, fetch_addr: f, wdata: wd};
      @(negedge clock_in);
      if (prg) prg_req = q;
      else cpu_req = q;
      @(negedge clock_in);
      s = prg ? prg_rsp : cpu_rsp;
      cpu_req = '0;
      prg_req = '0;
      `CHECK_EQ(s.valid, 1'b1, "response missing")
      ok = s.allowed;
      rd = s.rdata;
   endtask

   task automatic rd_chk(input logic prg, input logic [21:0] a,
                         input logic [21:0] f, input logic eok,
                         input logic [7:0] ed);
      access(prg, 1'b0, a, f, 8'h00);
      `CHECK_EQ(ok, eok, "read permit")
      `CHECK_EQ(rd, ed, "read data")
   endtask

   task automatic wr_chk(input logic prg, input logic [21:0] a,
                         input logic [7:0] d, input logic eok);
      access(prg, 1'b1, a, 22'h000000, d);
      `CHECK_EQ(ok, eok, "write permit")
   endtask

   task automatic ee_chk(input logic prg, input logic wr, input logic eok);
      @(negedge clock_in);
      if (prg) {prg_ee_valid, prg_ee_write} = {1'b1, wr};
      else {cpu_ee_valid, cpu_ee_write} = {1'b1, wr};
      #2;
      `CHECK_EQ(prg ? prg_ee_ok : cpu_ee_ok, eok, "eeprom permit")
      @(negedge clock_in);
      {prg_ee_valid, prg_ee_write, cpu_ee_valid, cpu_ee_write} = 4'h0;
   endtask

   task automatic erase(input logic chip, input logic [2:0] r);
      @(negedge clock_in);
      {chip_erase, blk_erase, erase_blk} = {chip, ~chip, r};
      @(negedge clock_in);
      {chip_erase, blk_erase} = 2'h0;
   endtask

   task automatic cfg_defaults;
      for (int i = 0; i < 6; i++) begin
         rd_chk(1'b0, 22'(`FBCP_CFG_EXT_BLK + i), 22'h0, 1'b1,
                CFG_DEF[i]);
      end
   endtask

   initial begin
      repeat (20000) @(posedge clock_in);
      errors++;
      $display("[FAIL] %0t run did not finish in time", $time);
      finish_test();
   end

   initial begin
      {arst_n_in, chip_erase, blk_erase, erase_blk} = 6'h00;
      {cpu_ee_valid, cpu_ee_write, prg_ee_valid, prg_ee_write} = 4'h0;
      mem_size = `FBCP_SZ_64K;
      cpu_req = '0;
      prg_req = '0;
      errors = 0;
      total_checks = 0;
      id_word = `FBCP_DEVID_WORD;
      do_reset(`FBCP_SZ_64K);
      cfg_defaults();
      rd_chk(1'b0, `FBCP_DEVID_LO, 22'h0, 1'b1, id_word[7:0]);
      rd_chk(1'b0, `FBCP_DEVID_HI, 22'h0, 1'b1, id_word[15:8]);
      end_test("reset values");
      rd_chk(1'b0, 22'h004000, 22'h000000, 1'b1, pat(22'h004000));
      wr_chk(1'b0, 22'h008000, 8'h99, 1'b1);
      rd_chk(1'b0, 22'h008000, 22'h000000, 1'b1, 8'h99);
      rd_chk(1'b0, 22'h010000, 22'h000000, 1'b1, 8'h00);
      wr_chk(1'b0, 22'h010000, 8'h77, 1'b0);
      rd_chk(1'b0, 22'h000000, 22'h000000, 1'b1, pat(22'h000000));
      end_test("table access");
      wr_chk(1'b1, `FBCP_CFG_EXT_BLK, 8'hfd, 1'b1);
      rd_chk(1'b1, 22'h004000, 22'h0, 1'b0, 8'h00);
      wr_chk(1'b1, 22'h004000, 8'h55, 1'b0);
      rd_chk(1'b0, 22'h004000, 22'h0, 1'b1, pat(22'h004000));
      wr_chk(1'b1, `FBCP_CFG_EXT_BLK, 8'hff, 1'b1);
      rd_chk(1'b0, `FBCP_CFG_EXT_BLK, 22'h0, 1'b1, 8'h0d);
      end_test("external lock");
      wr_chk(1'b0, `FBCP_CFG_WR_BLK, 8'hfe, 1'b1);
      rd_chk(1'b0, `FBCP_CFG_WR_BLK, 22'h0, 1'b1, 8'h0e);
      wr_chk(1'b0, 22'h000900, 8'h11, 1'b0);
      wr_chk(1'b1, 22'h000900, 8'h11, 1'b0);
      rd_chk(1'b0, 22'h000900, 22'h0, 1'b1, pat(22'h000900));
      end_test("write lock");
      wr_chk(1'b0, `FBCP_CFG_RD_BLK, 8'hf7, 1'b1);
      rd_chk(1'b0, 22'h00c100, 22'h00c000, 1'b1, pat(22'h00c100));
      rd_chk(1'b0, 22'h00c100, 22'h000900, 1'b0, 8'h00);
      end_test("cross read lock");
      ee_chk(1'b0, 1'b1, 1'b1);
      wr_chk(1'b0, `FBCP_CFG_WR_BOOT, 8'hdf, 1'b1);
      rd_chk(1'b0, `FBCP_CFG_WR_BOOT, 22'h0, 1'b1, 8'he0);
      wr_chk(1'b0, `FBCP_CFG_WR_BOOT, 8'h7f, 1'b1);
      rd_chk(1'b0, `FBCP_CFG_WR_BOOT, 22'h0, 1'b1, 8'h60);
      ee_chk(1'b0, 1'b1, 1'b0);
      ee_chk(1'b1, 1'b1, 1'b0);
      ee_chk(1'b0, 1'b0, 1'b1);
      ee_chk(1'b1, 1'b0, 1'b1);
      wr_chk(1'b1, `FBCP_CFG_EXT_BOOT, 8'h7f, 1'b1);
      ee_chk(1'b1, 1'b0, 1'b0);
      ee_chk(1'b0, 1'b0, 1'b1);
      end_test("eeprom locks");
      erase(1'b0, 3'h4);
      rd_chk(1'b0, `FBCP_CFG_RD_BLK, 22'h0, 1'b1, 8'h0f);
      rd_chk(1'b0, `FBCP_CFG_WR_BLK, 22'h0, 1'b1, 8'h0e);
      erase(1'b1, 3'h0);
      cfg_defaults();
      end_test("erase");
      do_reset(`FBCP_SZ_8K);
      wr_chk(1'b0, `FBCP_CFG_RD_BLK, 8'hfb, 1'b1);
      rd_chk(1'b0, `FBCP_CFG_RD_BLK, 22'h0, 1'b1, 8'h0b);
      wr_chk(1'b0, `FBCP_CFG_RD_BOOT, 8'hbf, 1'b1);
      rd_chk(1'b0, `FBCP_CFG_RD_BOOT, 22'h0, 1'b1, 8'h00);
      rd_chk(1'b0, 22'h000100, 22'h000300, 1'b0, 8'h00);
      rd_chk(1'b0, 22'h000200, 22'h000300, 1'b1, pat(22'h000200));
      rd_chk(1'b0, 22'h002000, 22'h000000, 1'b1, 8'h00);
      wr_chk(1'b0, `FBCP_CFG_RD_BLK, 8'hfe, 1'b1);
      rd_chk(1'b0, 22'h000200, 22'h000100, 1'b0, 8'h00);
      wr_chk(1'b0, `FBCP_CFG_WR_BOOT, 8'hbf, 1'b1);
      wr_chk(1'b0, 22'h000100, 8'h22, 1'b0);
      wr_chk(1'b1, `FBCP_CFG_WR_BOOT, 8'hdf, 1'b1);
      wr_chk(1'b0, `FBCP_CFG_RD_BLK, 8'h00, 1'b0);
      rd_chk(1'b0, `FBCP_CFG_RD_BLK, 22'h0, 1'b1, 8'h0a);
      end_test("small size");
      finish_test();
   end
endmodule
`default_nettype wire
